// file: art_timer.sv
// Auto-reload PWM/capture timer with APB register slave
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module art_timer
(
  // Clock, enable, reset
  input wire logic clk,
  input wire logic clk_en,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic timer_input_pin,
  output logic pwm_out_pin,
  output logic pwm_out_oe,
  // Interrupt request
  output logic timer_irq
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] mode_ctl_r;
  logic [2:0] flags_r;
  art_pkg::art_clkedge_t clkedge_r;
  logic [7:0] reload_capture_value_r;
  logic [7:0] compare_value_r;
  logic [7:0] up_counter_r;
  logic [art_pkg::PSC_W-1:0] timer_prescaler_r;
  logic [1:0] div3_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;
  logic pwm_r;
  logic [31:0] prdata_r;

  art_pkg::art_mode_t mode;
  logic wr;
  logic rd;
  logic [7:0] wbyte;
  logic load_cmd;
  logic load_port_wr;
  logic pin_rise;
  logic pin_fall;
  logic edge_evt;
  logic src_tick;
  logic presc_tick;
  logic [art_pkg::PSC_W-1:0] psc_inc;
  logic overflow;
  logic match;
  logic capture;
  logic cap_reset;
  logic ext_load;
  logic count_gate;
  logic [7:0] reg_idx;
  logic addr_ok;

  localparam logic [art_pkg::PSC_W-1:0] PSC_ONE = {{(art_pkg::PSC_W - 1){1'b0}}, 1'b1};

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // Zero-wait slave: every access completes in its first access cycle
  // Each register sits on an aligned word; misaligned or high addresses are refused
  assign reg_idx = paddr[9:2];
  assign addr_ok = ~|paddr[31:10] & ~|paddr[1:0];
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite & clk_en & addr_ok;
  assign rd = psel & penable & ~pwrite;
  assign wbyte = pwdata[7:0];
  assign mode = art_pkg::art_mode_t'(mode_ctl_r[1:0]);
  assign count_gate = mode_ctl_r[art_pkg::MC_GATE];
  assign load_cmd = wr && reg_idx == art_pkg::ADDR_MODE && wbyte[art_pkg::MC_LOAD];
  assign load_port_wr = wr && reg_idx == art_pkg::ADDR_LOAD;

  // Unmapped addresses answer with an error, upper address bits must be zero
  always_comb
  begin
    pslverr = 1'b0;
    if (psel && penable)
    begin
      unique case (reg_idx)
        art_pkg::ADDR_MODE, art_pkg::ADDR_FLAGS, art_pkg::ADDR_CLKEDGE, art_pkg::ADDR_RELOAD,
        art_pkg::ADDR_COMPARE, art_pkg::ADDR_LOAD, art_pkg::ADDR_PRESC: pslverr = ~addr_ok;
        default: pslverr = 1'b1;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Input pin synchroniser and edge detection
  // --------------------------------------------------------------------------
  // Third stage gives a clean previous value; the first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_s1_r <= timer_input_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign pin_rise = pin_s2_r & ~pin_s3_r;
  assign pin_fall = ~pin_s2_r & pin_s3_r;
  // Active edge only while detection is enabled, polarity from the edge select bit
  assign edge_evt = clkedge_r.edge_en & (clkedge_r.falling ? pin_fall : pin_rise);
  assign capture = edge_evt && (mode == art_pkg::MODE_CAPTURE || mode == art_pkg::MODE_CAP_RESET);
  assign cap_reset = edge_evt && mode == art_pkg::MODE_CAP_RESET;
  assign ext_load = edge_evt && mode == art_pkg::MODE_EXT_LOAD;

  // --------------------------------------------------------------------------
  // Clock source and prescaler
  // --------------------------------------------------------------------------
  // The pin source counts its rising edges; reserved selection gives no ticks
  always_comb
  begin
    unique case (clkedge_r.clk_sel)
      art_pkg::CLK_INT: src_tick = 1'b1;
      art_pkg::CLK_DIV3: src_tick = div3_r == art_pkg::DIV3_LAST;
      art_pkg::CLK_PIN: src_tick = pin_rise;
      art_pkg::CLK_RSVD: src_tick = 1'b0;
    endcase
  end

  assign psc_inc = timer_prescaler_r + PSC_ONE;
  // Tap n steps the counter each time prescaler bit n-1 rises, so ratio is 2^n
  always_comb
  begin
    if (clkedge_r.presc_tap == 3'h0)
      presc_tick = src_tick;
    else
      presc_tick = src_tick & psc_inc[clkedge_r.presc_tap - 3'h1] & ~timer_prescaler_r[clkedge_r.presc_tap - 3'h1];
  end

  // Divide-by-three phase runs only while counting so a stopped timer stays frozen
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      div3_r <= 2'h0;
    else if (clk_en && count_gate)
      div3_r <= (div3_r == art_pkg::DIV3_LAST) ? 2'h0 : div3_r + 2'h1;
  end

  // --------------------------------------------------------------------------
  // Counter events
  // --------------------------------------------------------------------------
  assign overflow = count_gate & presc_tick & (up_counter_r == art_pkg::BYTE_ONES);
  // Match is taken when the counter steps onto the compare value, once per visit
  assign match = count_gate & presc_tick & (up_counter_r + 8'h01 == compare_value_r) & ~overflow;

  // Prescaler: any counter load clears it, gate low freezes it
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      timer_prescaler_r <= art_pkg::PSC_ZERO;
    else if (clk_en)
    begin
      if (load_cmd || load_port_wr || cap_reset || ext_load || (overflow && mode == art_pkg::MODE_RELOAD))
        timer_prescaler_r <= art_pkg::PSC_ZERO;
      else if (count_gate && src_tick)
        timer_prescaler_r <= psc_inc;
    end
  end

  // Counter: software and edge loads win over the counting step
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      up_counter_r <= art_pkg::BYTE_ZERO;
    else if (clk_en)
    begin
      if (load_port_wr)
        up_counter_r <= wbyte;
      else if (load_cmd || ext_load)
        up_counter_r <= reload_capture_value_r;
      else if (cap_reset)
        up_counter_r <= art_pkg::BYTE_ZERO;
      else if (overflow && mode == art_pkg::MODE_RELOAD)
        up_counter_r <= reload_capture_value_r;
      else if (count_gate && presc_tick)
        up_counter_r <= up_counter_r + 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  // Load bit is a command and is never stored
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      mode_ctl_r <= art_pkg::MODE_RESET;
    else if (wr && reg_idx == art_pkg::ADDR_MODE)
      mode_ctl_r <= {1'b0, wbyte[6:0]};
  end

  // Clock/edge control; the reserved bit is kept at zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      clkedge_r <= art_pkg::art_clkedge_t'(art_pkg::BYTE_ZERO);
    else if (wr && reg_idx == art_pkg::ADDR_CLKEDGE)
      clkedge_r <= art_pkg::art_clkedge_t'({wbyte[7:5], 1'b0, wbyte[3:0]});
  end

  // Reload value: written by software, overwritten by a capture
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      reload_capture_value_r <= art_pkg::BYTE_ZERO;
    else if (clk_en)
    begin
      if (capture)
        reload_capture_value_r <= up_counter_r;
      else if (wr && reg_idx == art_pkg::ADDR_RELOAD)
        reload_capture_value_r <= wbyte;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      compare_value_r <= art_pkg::BYTE_ZERO;
    else if (wr && reg_idx == art_pkg::ADDR_COMPARE)
      compare_value_r <= wbyte;
  end

  // --------------------------------------------------------------------------
  // Event flags
  // --------------------------------------------------------------------------
  // Write zero clears, write one keeps; a same-cycle event wins over the clear
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      flags_r <= 3'h0;
    else if (clk_en)
    begin
      if (wr && reg_idx == art_pkg::ADDR_FLAGS)
        flags_r <= flags_r & wbyte[2:0] | {edge_evt, match, overflow};
      else
        flags_r <= flags_r | {edge_evt, match, overflow};
    end
  end

  // Each enable gates its own flag into the single request line
  assign timer_irq = |(flags_r & {mode_ctl_r[art_pkg::MC_EIE], mode_ctl_r[art_pkg::MC_MATCH_IRQ_ENABLE],
                                  mode_ctl_r[art_pkg::MC_OVERFLOW_IRQ_ENABLE]});

  // --------------------------------------------------------------------------
  // PWM output
  // --------------------------------------------------------------------------
  // Set on overflow and cleared on match in every mode
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pwm_r <= 1'b0;
    else if (clk_en)
    begin
      if (overflow)
        pwm_r <= 1'b1;
      else if (match)
        pwm_r <= 1'b0;
    end
  end

  // Pin is released, not driven low, while the output is disabled
  assign pwm_out_pin = pwm_r & mode_ctl_r[art_pkg::MC_PWM_DRIVE_ENABLE];
  assign pwm_out_oe = mode_ctl_r[art_pkg::MC_PWM_DRIVE_ENABLE];

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Registered in the setup cycle so data is stable in the access cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      // A refused address falls to the default and reads zero
      unique case (addr_ok ? reg_idx : art_pkg::BYTE_ZERO)
        art_pkg::ADDR_MODE: prdata_r <= {24'h000000, mode_ctl_r};
        art_pkg::ADDR_FLAGS: prdata_r <= {29'h0, flags_r};
        art_pkg::ADDR_CLKEDGE: prdata_r <= {24'h000000, clkedge_r};
        art_pkg::ADDR_RELOAD: prdata_r <= {24'h000000, reload_capture_value_r};
        art_pkg::ADDR_COMPARE: prdata_r <= {24'h000000, compare_value_r};
        art_pkg::ADDR_LOAD: prdata_r <= {24'h000000, up_counter_r};
        art_pkg::ADDR_PRESC: prdata_r <= {25'h0, timer_prescaler_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = rd ? prdata_r : 32'h0000_0000;

endmodule : art_timer
`default_nettype wire

// file: art_pkg.sv
// Constants, register map and field layout of the auto-reload PWM/capture timer
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package art_pkg;

  // --------------------------------------------------------------------------
  // Register word indices; the byte address on the bus is four times the index
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'hD5;
  localparam logic [7:0] ADDR_FLAGS = 8'hD6;
  localparam logic [7:0] ADDR_CLKEDGE = 8'hD7;
  localparam logic [7:0] ADDR_RELOAD = 8'hD9;
  localparam logic [7:0] ADDR_COMPARE = 8'hDA;
  localparam logic [7:0] ADDR_LOAD = 8'hDB;
  localparam logic [7:0] ADDR_PRESC = 8'hDC;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int MC_LOAD = 7;
  localparam int MC_GATE = 6;
  localparam int MC_PWM_DRIVE_ENABLE = 5;
  localparam int MC_EIE = 4;
  localparam int MC_MATCH_IRQ_ENABLE = 3;
  localparam int MC_OVERFLOW_IRQ_ENABLE = 2;
  localparam int FL_EDGE = 2;
  localparam int FL_MATCH = 1;
  localparam int FL_OVF = 0;
  localparam int CE_EDGE_EN = 2;
  localparam int CE_FALLING = 3;

  // --------------------------------------------------------------------------
  // Reset values and widths
  // --------------------------------------------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [6:0] PSC_ZERO = 7'h00;
  localparam logic [1:0] DIV3_LAST = 2'h2;
  localparam int PSC_W = 7;

  typedef enum logic [1:0] {MODE_RELOAD, MODE_CAPTURE, MODE_CAP_RESET, MODE_EXT_LOAD} art_mode_t;
  typedef enum logic [1:0] {CLK_INT, CLK_DIV3, CLK_PIN, CLK_RSVD} art_clk_t;

  // Control fields gathered from the clock/edge register
  typedef struct packed {
    logic [2:0] presc_tap;
    logic rsvd;
    logic falling;
    logic edge_en;
    art_clk_t clk_sel;
  } art_clkedge_t;

endpackage : art_pkg

// file: art_timer_monitor.sv
// Port checker of the auto-reload PWM/capture timer, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module art_timer_monitor
(
  // Clock and reset
  input wire logic clk,
  input wire logic clk_en,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and request
  input wire logic timer_input_pin,
  input wire logic pwm_out_pin,
  input wire logic pwm_out_oe,
  input wire logic timer_irq
);
  localparam logic [31:0] P_MODE = {22'h0, art_pkg::ADDR_MODE, 2'b00};
  localparam logic [31:0] P_FLG = {22'h0, art_pkg::ADDR_FLAGS, 2'b00};
  logic acc;
  logic [7:0] mode_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------------------
  // Mode shadow
  // ---------------------------------------------------------------------------
  // Kept so that each enable can be tied to the output it gates
  assign acc = psel && penable;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      mode_r <= 8'h00;
    else if (acc && pwrite && clk_en && paddr == P_MODE)
      mode_r <= {1'b0, pwdata[6:0]};
  end
  // Steps of a read and of a full flag clear with counting stopped and the edge request disabled
  sequence s_mode_read;
    acc && !pwrite && paddr == P_MODE;
  endsequence
  sequence s_clear_all;
    acc && pwrite && clk_en && paddr == P_FLG && pwdata[2:0] == 3'h0 && !mode_r[6] && !mode_r[4];
  endsequence
  // Pwm pin may not move while counting is stopped and the output enable is steady
  property p_freeze;
    $past(rst_b) && !$past(mode_r[6]) && $stable(pwm_out_oe) |-> $stable(pwm_out_pin);
  endproperty
  a_oe_gates_pwm: assert property (!pwm_out_oe |-> !pwm_out_pin)
    else $error("pwm driven while disabled");
  a_oe_follows_bit: assert property (pwm_out_oe == mode_r[5])
    else $error("output enable differs from mode bit");
  a_irq_needs_enable: assert property (mode_r[4:2] == 3'h0 |-> !timer_irq)
    else $error("request with all enables clear");
  a_mode_readback: assert property (s_mode_read |-> prdata == {24'h000000, mode_r})
    else $error("mode read wrong or load bit seen");
  a_flag_upper_zero: assert property (acc && !pwrite && paddr == P_FLG |-> prdata[31:3] == 29'h0)
    else $error("unused flag bits set");
  a_reset_idle: assert property ($rose(rst_b) |-> !timer_irq && !pwm_out_oe && !pwm_out_pin)
    else $error("outputs active after reset");
  a_gate_freeze: assert property (p_freeze)
    else $error("pwm moved while counting stopped");
  a_clear_all: assert property (s_clear_all |=> !timer_irq)
    else $error("request left after flags cleared");
  a_unmapped_err: assert property (acc && paddr == 32'h00000360 |-> pslverr)
    else $error("no error on unmapped address");
endmodule : art_timer_monitor

bind art_timer art_timer_monitor i_mon (.clk(clk), .clk_en(clk_en), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_input_pin(timer_input_pin), .pwm_out_pin(pwm_out_pin), .pwm_out_oe(pwm_out_oe),
  .timer_irq(timer_irq));
`default_nettype wire

// file: art_pin_partner.sv
// Pin partner: edge source on the timer input and a load that times pwm pulses
`timescale 1ns/100ps
`default_nettype none
module art_pin_partner
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Edge source control
  input wire logic run,
  input wire logic [7:0] gap,
  // Pins
  input wire logic pwm_out_pin,
  input wire logic pwm_out_oe,
  output logic timer_input_pin,
  // Pulse measurement
  output logic [15:0] hi_width,
  output logic [7:0] hi_count
);
  logic pin_r = 1'b0;
  logic [7:0] tick_r = 8'h01;
  logic [15:0] len_r = 16'h0000;
  assign timer_input_pin = pin_r;
  // Square wave of half period gap; the pin holds its level while idle
  always @(posedge clk)
  begin
    if (!run)
      tick_r <= 8'h01;
    else if (tick_r == gap)
    begin
      tick_r <= 8'h01;
      pin_r <= !pin_r;
    end
    else
      tick_r <= tick_r + 8'h01;
  end
  // Load sees the waveform only while the output is driven
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      len_r <= 16'h0000;
      hi_width <= 16'h0000;
      hi_count <= 8'h00;
    end
    else if (pwm_out_oe && pwm_out_pin)
      len_r <= len_r + 16'h0001;
    else if (len_r != 16'h0000)
    begin
      hi_width <= len_r;
      hi_count <= hi_count + 8'h01;
      len_r <= 16'h0000;
    end
  end
endmodule : art_pin_partner
`default_nettype wire

// file: art_timer_tb.sv
// Self-checking bench of the auto-reload PWM/capture timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %h got %h", nm, e, s); end end
module art_timer_tb;
  localparam logic [7:0] A_MODE = art_pkg::ADDR_MODE;
  localparam logic [7:0] A_FLG = art_pkg::ADDR_FLAGS;
  localparam logic [7:0] A_CE = art_pkg::ADDR_CLKEDGE;
  localparam logic [7:0] A_RLD = art_pkg::ADDR_RELOAD;
  localparam logic [7:0] A_LD = art_pkg::ADDR_LOAD;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pin, pwm, oe, irq, last_err;
  logic run = 1'b0;
  logic en = 1'b1;
  logic [7:0] gap = 8'h04;
  logic [15:0] hi_width;
  logic [7:0] hi_count, q, r, c, v, n;
  int bad_count = 0;
  int tests_run = 0;
  int k, t, dv, ld;
  // ---------------------------------------------------------------------------
  // Clock, design and pin partner
  // ---------------------------------------------------------------------------
  always #25 clk = !clk;
  art_timer i_dut (.clk(clk), .clk_en(en), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_input_pin(pin), .pwm_out_pin(pwm), .pwm_out_oe(oe), .timer_irq(irq));
  art_pin_partner i_pins (.clk(clk), .rst_b(rst_b), .run(run), .gap(gap), .pwm_out_pin(pwm),
    .pwm_out_oe(oe), .timer_input_pin(pin), .hi_width(hi_width), .hi_count(hi_count));
  // Expected high time: compare minus reload steps of one divider period each; the prescaler
  // clear on overflow lets a tap's first step come half a period early (lead cycles)
  function automatic logic [15:0] pwm_hi(input logic [7:0] rl, cp, input int div, lead);
    return 16'(int'(cp - rl) * div - lead);
  endfunction : pwm_hi
  // One APB transfer to a word-indexed register; read data and error taken at the completing edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, a, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // A few pin toggles, then settle past the input synchroniser
  task automatic pulse();
    gap <= 8'h04;
    run <= 1'b1;
    repeat (12) @(posedge clk);
    run <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Watchdog, far beyond the roughly five thousand cycles the tests need
  initial
  begin
    #2000000;
    bad_count++;
    summarize();
  end
  // Main sequence
  initial
  begin
    k = $urandom(72);
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    xfer(0, A_MODE, 8'h00);
    `CHK("mode reset", 8'h00, q)
    xfer(0, 8'hD8, 8'h00);
    `CHK("unmapped error", 1'b1, last_err)
    $display("test reset done");
    // Pwm high time over clock source and tap; gate is off while clocking changes
    // Last pass clocks from the pin, which toggles every cycle: one rising edge per two cycles
    for (k = 0; k < 4; k++)
    begin
      r = 8'($urandom_range(8'hC7));
      c = r + 8'h01 + 8'($urandom_range(8'h27));
      gap <= 8'h01;
      run <= (k == 3);
      xfer(1, A_MODE, 8'h2C);
      xfer(1, A_CE, (k == 1) ? 8'h20 : (k == 2) ? 8'h01 : (k == 3) ? 8'h02 : 8'h00);
      xfer(1, A_RLD, r);
      xfer(1, art_pkg::ADDR_COMPARE, c);
      xfer(1, A_MODE, 8'hEC);
      n = hi_count;
      for (t = 0; t < 4000 && 8'(hi_count - n) < 8'h02; t++)
        @(posedge clk);
      dv = (k == 0) ? 1 : (k == 3) ? 2 : k + 1;
      ld = (k == 1) ? 1 : 0;
      `CHK("pwm high", pwm_hi(r, c, dv, ld), hi_width)
    end
    run <= 1'b0;
    xfer(1, A_MODE, 8'h2C);
    xfer(0, A_LD, 8'h00);
    v = q;
    xfer(0, A_LD, 8'h00);
    `CHK("frozen counter", v, q)
    xfer(0, A_FLG, 8'h00);
    `CHK("flags", 8'h03, q)
    `CHK("irq", 1'b1, irq)
    xfer(1, A_FLG, 8'h06);
    xfer(0, A_FLG, 8'h00);
    `CHK("flags kept", 8'h02, q)
    xfer(1, A_MODE, 8'h24);
    xfer(0, A_FLG, 8'h00);
    `CHK("irq masked", 1'b0, irq)
    xfer(1, A_FLG, 8'h00);
    $display("test pwm done");
    // Load port and load command
    v = 8'($urandom);
    xfer(1, A_LD, v);
    xfer(0, A_LD, 8'h00);
    `CHK("load port", v, q)
    r = 8'($urandom);
    xfer(1, A_RLD, r);
    xfer(1, A_MODE, 8'h80);
    xfer(0, A_LD, 8'h00);
    `CHK("load cmd", r, q)
    // Clock enable low blocks writes to a counter clocked from the idle pin, reads still answer
    xfer(1, A_MODE, 8'h40);
    en <= 1'b0;
    xfer(0, A_LD, 8'h00);
    v = q;
    xfer(1, A_LD, ~v);
    xfer(0, A_LD, 8'h00);
    `CHK("clock enable hold", v, q)
    en <= 1'b1;
    xfer(1, A_MODE, 8'h00);
    $display("test load done");
    // Capture of a stopped counter on rising edges
    xfer(1, A_LD, v);
    xfer(1, A_CE, 8'h04);
    xfer(1, A_MODE, 8'h01);
    pulse();
    xfer(0, A_RLD, 8'h00);
    `CHK("capture", v, q)
    xfer(0, A_FLG, 8'h00);
    `CHK("edge flag", 8'h04, q)
    // Load on falling edges while stopped
    xfer(1, A_RLD, r);
    xfer(1, A_LD, ~r);
    xfer(1, A_CE, 8'h0C);
    xfer(1, A_MODE, 8'h03);
    pulse();
    xfer(0, A_LD, 8'h00);
    `CHK("edge load", r, q)
    // Period measurement on both polarities, internal clock only
    for (k = 0; k < 2; k++)
    begin
      n = 8'h05 + 8'($urandom_range(8'h23));
      xfer(1, A_CE, (k == 1) ? 8'h0C : 8'h04);
      xfer(1, A_MODE, 8'h42);
      gap <= n;
      run <= 1'b1;
      repeat (6 * n) @(posedge clk);
      run <= 1'b0;
      xfer(1, A_MODE, 8'h02);
      xfer(0, A_RLD, 8'h00);
      `CHK("period", 8'(2 * n - 1), q)
    end
    $display("test edges done");
    summarize();
  end
endmodule : art_timer_tb
`default_nettype wire
